//--- pkg/cfgacc_pkg.sv
// Purpose: Shared constants for the configuration access message link
// Assumes: One token per transfer, nine bits wide (control flag plus byte)
// Notes:   Multi-byte fields travel most significant byte first
package cfgacc_pkg;
  // ************************************************************
  // Token values
  // ************************************************************
  localparam logic [7:0] CT_WRITE = 8'hC0;
  localparam logic [7:0] CT_READ  = 8'hC1;
  localparam logic [7:0] CT_END   = 8'h01;
  localparam logic [7:0] CT_ACK   = 8'h03;
  localparam logic [7:0] CT_NACK  = 8'h04;
  // ************************************************************
  // Field sizes in bytes and destination suffixes
  // ************************************************************
  localparam int          RID_BYTES  = 3;
  localparam int          REG_BYTES  = 2;
  localparam int          DATA_BYTES = 4;
  localparam logic [7:0]  NOREPLY_LO = 8'hFF;
  localparam logic [15:0] TILE_SUFX  = 16'hC20C;
  localparam logic [15:0] NODE_SUFX  = 16'hC30C;
  localparam logic [7:0]  PERIPH_LO  = 8'h02;
  // ************************************************************
  // Processor-status resource identifiers
  // ************************************************************
  localparam int          PS_SHIFT   = 8;
  localparam logic [7:0]  PS_RTYPE   = 8'h0B;
  localparam logic [15:0] NUM_REGS   = 16'h0010;
  function automatic logic [31:0] ps_resource(input logic [15:0] regnum);
    ps_resource = ({16'h0000, regnum} << PS_SHIFT) | {24'h000000, PS_RTYPE};
  endfunction : ps_resource
endpackage : cfgacc_pkg

//--- pkg/cfgacc_if.sv
`timescale 1ns/1ps
// Purpose: Token link between requester and configuration endpoint
// Assumes: Both ends on one clock
// Notes:   req carries requests, rsp carries replies; bit 8 marks control
interface cfgacc_if;
  logic        req_valid;
  logic [8:0]  req_tok;
  logic        req_ready;
  logic        rsp_valid;
  logic [8:0]  rsp_tok;
  logic [23:0] rsp_dest;
  logic        rsp_ready;
  modport requester (output req_valid, output req_tok, input req_ready,
                     input rsp_valid, input rsp_tok, input rsp_dest,
                     output rsp_ready);
  modport endpoint  (input req_valid, input req_tok, output req_ready,
                     output rsp_valid, output rsp_tok, output rsp_dest,
                     input rsp_ready);
endinterface : cfgacc_if

//--- hw/cfgacc_endpoint.sv
`timescale 1ns/1ps
// Purpose: Configuration endpoint that parses token messages and replies
// Assumes: Requester keeps its own framing rules
// Notes:   Holds a small register bank; status port reads and writes locally
// Functional notes
// - Requests carry 24-bit reply channel-end identifier
// - Reply identifier is node plus channel; route
// - Reply low byte all ones suppresses write reply
// - Multi-byte fields sent most significant byte first
// - Status resource is number shifted eight, ORed
// - Status read and write move full words
// - Node access uses node id plus suffix
// - Peripheral access uses node, peripheral, two
// - Write: 192, reply id, register, data, 1
// - Write reply: 3,1 success or 4,1 failure
// - Read: 193, reply id, register, 1
// - Read reply: 3, data, 1 or 4,1
// - Read reply data is exactly 32 bits
module cfgacc_endpoint #(
  parameter logic [15:0] NREGS = cfgacc_pkg::NUM_REGS
) (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // Link
  cfgacc_if.endpoint       link,
  // Local processor-status port
  input  wire logic        i_ps_wr,
  input  wire logic        i_ps_rd,
  input  wire logic [15:0] i_ps_reg,
  input  wire logic [31:0] i_ps_wdata,
  output logic      [31:0] o_ps_rdata,
  output logic      [31:0] o_ps_res,
  output logic             o_busy
);
  // ************************************************************
  // State and storage
  // ************************************************************
  typedef enum logic [2:0] {S_CMD, S_RID, S_REG, S_DAT, S_END, S_DRAIN, S_RSP}
    cfgacc_st_t;
  cfgacc_st_t  st_r;
  logic        is_wr_r;
  logic        bad_r;
  logic [2:0]  cnt_r;
  logic [23:0] rid_r;
  logic [15:0] reg_r;
  logic [31:0] dat_r;
  logic [2:0]  rsp_idx_r;
  logic        rsp_valid_r;
  logic [8:0]  rsp_tok_r;
  logic [31:0] bank_r [16];
  logic [31:0] ps_rdata_r;
  logic [31:0] ps_res_r;

  wire logic       take     = link.req_valid && (st_r != S_RSP);
  wire logic       is_ctl   = link.req_tok[8];
  wire logic [7:0] tok_b    = link.req_tok[7:0];
  wire logic       reg_ok   = reg_r < NREGS;
  wire logic       ok       = !bad_r && reg_ok;
  wire logic       quiet    = is_wr_r && (rid_r[7:0] == cfgacc_pkg::NOREPLY_LO);
  // Reply token sequence: index 0 status, then 1..4 data and 5 end with read data, else 1 end
  wire logic       with_dat = !is_wr_r && ok;
  wire logic [2:0] last_idx = with_dat ? 3'd5 : 3'd1;
  // Shift keeps every byte select in range, whatever the index holds
  wire logic [31:0] dat_sh  = dat_r << {rsp_idx_r - 3'd1, 3'b000};
  wire logic [8:0] rsp_tok_nxt =
    (rsp_idx_r == 3'd0) ? {1'b1, ok ? cfgacc_pkg::CT_ACK : cfgacc_pkg::CT_NACK} :
    (rsp_idx_r == last_idx) ? {1'b1, cfgacc_pkg::CT_END} :
    {1'b0, dat_sh[31:24]};
  wire logic       rsp_fire = rsp_valid_r && link.rsp_ready;

  assign link.req_ready = (st_r != S_RSP);
  assign link.rsp_valid = rsp_valid_r;
  assign link.rsp_tok   = rsp_tok_r;
  assign link.rsp_dest  = rid_r;
  assign o_ps_rdata     = ps_rdata_r;
  assign o_ps_res       = ps_res_r;
  assign o_busy         = rsp_valid_r;

  // ************************************************************
  // Request parser
  // ************************************************************
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st_r    <= S_CMD;
      is_wr_r <= 1'b0;
      bad_r   <= 1'b0;
      cnt_r   <= 3'd0;
      rid_r   <= 24'h000000;
      reg_r   <= 16'h0000;
      dat_r   <= 32'h00000000;
    end else if (take) begin
      cnt_r <= cnt_r + 3'd1;
      // A stray control token ends the frame early and forces a failure
      if (is_ctl && st_r != S_CMD && st_r != S_END && st_r != S_DRAIN) begin
        bad_r <= 1'b1;
        cnt_r <= 3'd0;
        st_r  <= (tok_b == cfgacc_pkg::CT_END) ? S_RSP : S_DRAIN;
      end else begin
        case (st_r)
          S_CMD: begin
            cnt_r <= 3'd0;
            bad_r <= 1'b0;
            if (is_ctl && tok_b == cfgacc_pkg::CT_WRITE) begin
              is_wr_r <= 1'b1;
              st_r    <= S_RID;
            end else if (is_ctl && tok_b == cfgacc_pkg::CT_READ) begin
              is_wr_r <= 1'b0;
              st_r    <= S_RID;
            end
          end
          S_RID: begin
            rid_r <= {rid_r[15:0], tok_b};
            if (cnt_r == 3'(cfgacc_pkg::RID_BYTES - 1)) begin
              cnt_r <= 3'd0;
              st_r  <= S_REG;
            end
          end
          S_REG: begin
            reg_r <= {reg_r[7:0], tok_b};
            if (cnt_r == 3'(cfgacc_pkg::REG_BYTES - 1)) begin
              cnt_r <= 3'd0;
              st_r  <= is_wr_r ? S_DAT : S_END;
            end
          end
          S_DAT: begin
            dat_r <= {dat_r[23:0], tok_b};
            if (cnt_r == 3'(cfgacc_pkg::DATA_BYTES - 1)) begin
              st_r <= S_END;
            end
          end
          S_END: begin
            if (is_ctl && tok_b == cfgacc_pkg::CT_END) begin
              st_r <= S_RSP;
              if (!is_wr_r && reg_ok) begin
                dat_r <= bank_r[reg_r[3:0]];
              end
            end else begin
              bad_r <= 1'b1;
              st_r  <= S_DRAIN;
            end
          end
          S_DRAIN: begin
            if (is_ctl && tok_b == cfgacc_pkg::CT_END) begin
              st_r <= S_RSP;
            end
          end
          default: st_r <= S_CMD;
        endcase
      end
    end else if (st_r == S_RSP && (quiet && !rsp_valid_r || rsp_fire &&
                 rsp_idx_r == last_idx + 3'd1)) begin // Quiet writes leave at once; others once end token is taken
      st_r <= S_CMD;
    end
  end

  // ************************************************************
  // Reply sender
  // ************************************************************
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rsp_valid_r <= 1'b0;
      rsp_idx_r   <= 3'd0;
      rsp_tok_r   <= 9'h000;
    end else if (st_r != S_RSP) begin
      rsp_valid_r <= 1'b0;
      rsp_idx_r   <= 3'd0;
    end else if (!rsp_valid_r && !quiet) begin
      rsp_valid_r <= 1'b1;
      rsp_tok_r   <= rsp_tok_nxt;
      rsp_idx_r   <= rsp_idx_r + 3'd1;
    end else if (rsp_fire) begin
      rsp_valid_r <= (rsp_idx_r <= last_idx) && (rsp_idx_r != 3'd0);
      rsp_tok_r   <= rsp_tok_nxt;
      rsp_idx_r   <= rsp_idx_r + 3'd1;
    end
  end

  // ************************************************************
  // Register bank and local status access
  // ************************************************************
  // Write lands on the end token even when the reply is suppressed
  wire logic link_wr = take && st_r == S_END && is_ctl &&
                       tok_b == cfgacc_pkg::CT_END && is_wr_r && !bad_r && reg_ok;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < 16; i++) begin
        bank_r[i] <= 32'h00000000;
      end
      ps_rdata_r <= 32'h00000000;
      ps_res_r   <= 32'h00000000;
    end else begin
      if (link_wr) begin
        bank_r[reg_r[3:0]] <= dat_r;
      end else if (i_ps_wr && i_ps_reg < NREGS) begin
        bank_r[i_ps_reg[3:0]] <= i_ps_wdata;
      end
      if (i_ps_rd) begin
        ps_rdata_r <= (i_ps_reg < NREGS) ? bank_r[i_ps_reg[3:0]] : 32'h00000000;
      end
      if (i_ps_rd || i_ps_wr) begin
        ps_res_r <= cfgacc_pkg::ps_resource(i_ps_reg);
      end
    end
  end
endmodule : cfgacc_endpoint

//--- hw/cfgacc_requester.sv
`timescale 1ns/1ps
// Purpose: Requester end that frames read and write messages
// Assumes: One request outstanding at a time
// Notes:   Destination is formed from target kind and identifiers
module cfgacc_requester (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // Link
  cfgacc_if.requester      link,
  // User request
  input  wire logic        i_start,
  input  wire logic        i_write,
  input  wire logic [1:0]  i_kind,
  input  wire logic [23:0] i_target_id,
  input  wire logic [7:0]  i_periph,
  input  wire logic [23:0] i_reply_id,
  input  wire logic [15:0] i_regnum,
  input  wire logic [31:0] i_wdata,
  // User answer
  output logic             o_busy,
  output logic      [31:0] o_dest,
  output logic             o_done,
  output logic             o_ok,
  output logic      [31:0] o_rdata
);
  logic        busy_r, done_r, ok_r, rx_r;
  logic [3:0]  idx_r;
  logic [3:0]  len_r;
  logic [8:0]  msg_r [11];
  logic [31:0] dest_r, rdata_r;
  wire  logic  quiet = i_write && (i_reply_id[7:0] == cfgacc_pkg::NOREPLY_LO);
  // ************************************************************
  // Destination select
  // ************************************************************
  wire logic [31:0] dest_nxt =
    (i_kind == 2'd0) ? {i_target_id[15:0], cfgacc_pkg::TILE_SUFX} :
    (i_kind == 2'd1) ? {i_target_id[15:0], cfgacc_pkg::NODE_SUFX} :
    {i_target_id[15:0], i_periph, cfgacc_pkg::PERIPH_LO};
  assign link.req_valid = busy_r && !rx_r;
  assign link.req_tok   = msg_r[idx_r];
  assign link.rsp_ready = 1'b1;
  assign o_busy  = busy_r;
  assign o_dest  = dest_r;
  assign o_done  = done_r;
  assign o_ok    = ok_r;
  assign o_rdata = rdata_r;
  wire logic sent_last = link.req_valid && link.req_ready && idx_r == len_r;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      ok_r   <= 1'b0;
      rx_r   <= 1'b0;
      idx_r  <= 4'd0;
      len_r  <= 4'd0;
      dest_r <= 32'h00000000;
      rdata_r <= 32'h00000000;
      for (int i = 0; i < 11; i++) begin
        msg_r[i] <= 9'h000;
      end
    end else begin
      done_r <= 1'b0;
      if (!busy_r && i_start) begin
        busy_r <= 1'b1;
        idx_r  <= 4'd0;
        dest_r <= dest_nxt;
        msg_r[0] <= {1'b1, i_write ? cfgacc_pkg::CT_WRITE
                           : cfgacc_pkg::CT_READ};
        msg_r[1] <= {1'b0, i_reply_id[23:16]};
        msg_r[2] <= {1'b0, i_reply_id[15:8]};
        msg_r[3] <= {1'b0, i_reply_id[7:0]};
        msg_r[4] <= {1'b0, i_regnum[15:8]};
        msg_r[5] <= {1'b0, i_regnum[7:0]};
        msg_r[6] <= i_write ? {1'b0, i_wdata[31:24]} : {1'b1, cfgacc_pkg::CT_END};
        msg_r[7] <= {1'b0, i_wdata[23:16]};
        msg_r[8] <= {1'b0, i_wdata[15:8]};
        msg_r[9] <= {1'b0, i_wdata[7:0]};
        msg_r[10] <= {1'b1, cfgacc_pkg::CT_END};
        len_r  <= i_write ? 4'd10 : 4'd6;
        rx_r   <= 1'b0;
        ok_r   <= 1'b0;
        // Suppressed writes complete as soon as the last token leaves
        if (quiet) begin
          ok_r <= 1'b1;
        end
      end else if (busy_r && !rx_r) begin
        // Index parks on the last token so it never points past the message
        if (link.req_valid && link.req_ready && !sent_last) begin
          idx_r <= idx_r + 4'd1;
        end
        if (sent_last) begin
          rx_r <= !(msg_r[0][7:0] == cfgacc_pkg::CT_WRITE && msg_r[3][7:0] ==
                    cfgacc_pkg::NOREPLY_LO);
          busy_r <= !(msg_r[0][7:0] == cfgacc_pkg::CT_WRITE && msg_r[3][7:0] ==
                      cfgacc_pkg::NOREPLY_LO);
          done_r <= msg_r[0][7:0] == cfgacc_pkg::CT_WRITE && msg_r[3][7:0] ==
                    cfgacc_pkg::NOREPLY_LO;
        end
      end else if (rx_r && link.rsp_valid) begin
        // control flag decides framing, data bytes shift in MSB first
        if (link.rsp_tok[8] && link.rsp_tok[7:0] == cfgacc_pkg::CT_ACK) begin
          ok_r <= 1'b1;
        end else if (link.rsp_tok[8] && link.rsp_tok[7:0] == cfgacc_pkg::CT_NACK) begin
          ok_r <= 1'b0;
        end else if (!link.rsp_tok[8]) begin
          rdata_r <= {rdata_r[23:0], link.rsp_tok[7:0]};
        end else if (link.rsp_tok[7:0] == cfgacc_pkg::CT_END) begin
          busy_r <= 1'b0;
          rx_r   <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end
endmodule : cfgacc_requester

//--- tb/cfgacc_link_assertions.sv
// Purpose: Assertions on the config access token link
// Assumes: One clock, asynchronous active-high reset
// Notes:   Requester takes every reply token at once
`timescale 1ns/1ps
module cfgacc_link_assertions (
  // Clock and reset
  input wire logic        i_clock,
  input wire logic        i_rst,
  // Link signals
  input wire logic        req_valid,
  input wire logic [8:0]  req_tok,
  input wire logic        req_ready,
  input wire logic        rsp_valid,
  input wire logic [8:0]  rsp_tok,
  input wire logic [23:0] rsp_dest,
  input wire logic        rsp_ready
);
  // ********
  // Request tracking
  // ********
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  logic        rd_r;
  logic [3:0]  idx_r;
  logic [23:0] rid_r;
  wire         take    = req_valid && req_ready;
  wire         dat     = take && !req_tok[8];
  wire         cmd     = take && (req_tok == 9'h1C0 || req_tok == 9'h1C1);
  wire         fin     = take && req_tok == 9'h101 && idx_r == (rd_r ? 4'h5 : 4'h9);
  wire         sup     = !rd_r && rid_r[7:0] == 8'hFF;
  // Index saturates so stray bytes before a command never look complete
  wire [3:0]   idx_nxt = cmd ? 4'h0 : (dat && idx_r != 4'hF) ? idx_r + 4'h1 : idx_r;
  wire [23:0]  rid_nxt = (dat && idx_r < 4'h3) ? {rid_r[15:0], req_tok[7:0]} : rid_r;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rd_r  <= 1'b0;
      idx_r <= 4'hF;
      rid_r <= 24'h000000;
    end else begin
      rd_r  <= cmd ? req_tok[0] : rd_r;
      idx_r <= idx_nxt;
      rid_r <= rid_nxt;
    end
  end
  sequence s_close;
    rsp_valid && rsp_tok == 9'h101;
  endsequence
  sequence s_read_data;
    (rsp_valid && !rsp_tok[8]) [*4] ##1 s_close;
  endsequence
  property p_rid_route; rsp_valid |-> rsp_dest == rid_r; endproperty
  property p_reply_due; fin && !sup |-> ##[1:2] (rsp_valid && rsp_tok[8]); endproperty
  property p_no_reply; fin && sup |=> !rsp_valid [*4]; endproperty
  property p_first_tok; $rose(rsp_valid) |-> rsp_tok inside {9'h103, 9'h104}; endproperty
  property p_read_data; rsp_valid && rsp_tok == 9'h103 && rd_r |=> s_read_data; endproperty
  property p_write_ack; rsp_valid && rsp_tok == 9'h103 && !rd_r |=> s_close; endproperty
  property p_nack_end; rsp_valid && rsp_tok == 9'h104 |=> s_close; endproperty
  property p_reply_end; s_close |=> !rsp_valid; endproperty
  a_rid_route: assert property (p_rid_route)
    else $error("reply sent to wrong channel end");
  a_reply_due: assert property (p_reply_due)
    else $error("no reply after end token");
  a_no_reply: assert property (p_no_reply)
    else $error("reply sent for quiet write");
  a_first_tok: assert property (p_first_tok)
    else $error("reply opens with wrong token");
  a_read_data: assert property (p_read_data)
    else $error("read reply not four data bytes then end");
  a_write_ack: assert property (p_write_ack)
    else $error("write success not closed by end token");
  a_nack_end: assert property (p_nack_end)
    else $error("failure not closed by end token");
  a_reply_end: assert property (p_reply_end)
    else $error("reply continues past end token");
endmodule : cfgacc_link_assertions

//--- tb/cfgacc_tb.sv
// Purpose: Self-checking bench for both ends of the config access link
// Assumes: Inputs change on the falling edge
// Notes:   Second link lets the bench send broken requests
`timescale 1ns/1ps
module cfgacc_tb;
  // ********
  // Signals and instances
  // ********
  logic        i_clock = 1'b0;
  logic        i_rst   = 1'b1;
  logic        start, write, ps_wr, ps_rd, ok, done, busy, ep_busy;
  logic [1:0]  kind;
  logic [7:0]  periph;
  logic [15:0] regnum, ps_reg;
  logic [23:0] target_id, reply_id, seen_dest;
  logic [31:0] wdata, ps_wdata, dest, rdata, ps_rdata, ps_res;
  logic [8:0]  rq[$], rs[$], rs2[$];
  int          failures, checks_done, cycles;
  cfgacc_if link ();
  cfgacc_if link2 ();
  always #10 i_clock = ~i_clock;
  cfgacc_requester cfgacc_requester_inst (.i_clock(i_clock), .i_rst(i_rst), .link(link),
    .i_start(start), .i_write(write), .i_kind(kind), .i_target_id(target_id),
    .i_periph(periph), .i_reply_id(reply_id), .i_regnum(regnum), .i_wdata(wdata),
    .o_busy(busy), .o_dest(dest), .o_done(done), .o_ok(ok), .o_rdata(rdata));
  cfgacc_endpoint cfgacc_endpoint_inst (.i_clock(i_clock), .i_rst(i_rst), .link(link),
    .i_ps_wr(ps_wr), .i_ps_rd(ps_rd), .i_ps_reg(ps_reg), .i_ps_wdata(ps_wdata),
    .o_ps_rdata(ps_rdata), .o_ps_res(ps_res), .o_busy(ep_busy));
  cfgacc_endpoint cfgacc_endpoint_inst2 (.i_clock(i_clock), .i_rst(i_rst), .link(link2),
    .i_ps_wr(ps_wr), .i_ps_rd(ps_rd), .i_ps_reg(ps_reg), .i_ps_wdata(ps_wdata),
    .o_ps_rdata(), .o_ps_res(), .o_busy());
  cfgacc_link_assertions cfgacc_link_assertions_inst (.i_clock(i_clock), .i_rst(i_rst),
    .req_valid(link.req_valid), .req_tok(link.req_tok), .req_ready(link.req_ready),
    .rsp_valid(link.rsp_valid), .rsp_tok(link.rsp_tok), .rsp_dest(link.rsp_dest),
    .rsp_ready(link.rsp_ready));
  // Wire monitor and hang limit
  always @(posedge i_clock) begin
    cycles++;
    if (link.req_valid && link.req_ready) rq.push_back(link.req_tok);
    if (link.rsp_valid && link.rsp_ready) rs.push_back(link.rsp_tok);
    if (link.rsp_valid) seen_dest = link.rsp_dest;
    if (link2.rsp_valid && link2.rsp_ready) rs2.push_back(link2.rsp_tok);
    if (cycles == 5000) begin
      failures++;
      complete_run();
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic check_q(input string nm, input logic [8:0] sq[$], input logic [8:0] eq[$]);
    check(nm, 32'(sq.size()), 32'(eq.size()));
    if (sq.size() == eq.size())
      foreach (eq[i]) check(nm, 32'(sq[i]), 32'(eq[i]));
  endtask : check_q
  task automatic run_req(input logic w, input logic [1:0] k, input logic [23:0] r,
                         input logic [15:0] g, input logic [31:0] d);
    rq = {};
    rs = {};
    @(negedge i_clock);
    write = w;
    kind = k;
    reply_id = r;
    regnum = g;
    wdata = d;
    start = 1'b1;
    @(negedge i_clock);
    start = 1'b0;
    while (done !== 1'b1) @(negedge i_clock);
    repeat (4) @(negedge i_clock);
    check("req busy", 32'(busy), 0);
    check("ep busy", 32'(ep_busy), 0);
  endtask : run_req
  // Write then read back, both messages checked byte by byte on the wire
  task automatic t_write_read();
    run_req(1'b1, 2'h0, 24'h123456, 16'h0005, 32'hA1B2C3D4);
    check("write ok", 32'(ok), 1);
    check("tile dest", dest, 32'hABCDC20C);
    check("reply dest", 32'(seen_dest), 32'h00123456);
    check_q("write req", rq, '{9'h1C0, 9'h012, 9'h034, 9'h056, 9'h000, 9'h005,
            9'h0A1, 9'h0B2, 9'h0C3, 9'h0D4, 9'h101});
    check_q("write rsp", rs, '{9'h103, 9'h101});
    run_req(1'b0, 2'h1, 24'h123456, 16'h0005, 32'h00000000);
    check_q("read req", rq, '{9'h1C1, 9'h012, 9'h034, 9'h056, 9'h000, 9'h005,
            9'h101});
    check_q("read rsp", rs, '{9'h103, 9'h0A1, 9'h0B2, 9'h0C3, 9'h0D4, 9'h101});
    check("read data", rdata, 32'hA1B2C3D4);
    check("node dest", dest, 32'hABCDC30C);
  endtask : t_write_read
  // Quiet writes through every target kind, the last one read back
  task automatic t_kinds();
    for (int k = 0; k < 4; k++) begin
      run_req(1'b1, 2'(k), 24'h1234FF, 16'h0001, 32'h00000010 + k);
      check("quiet rsp", 32'(rs.size()), 0);
      check("kind dest", dest, k == 0 ? 32'hABCDC20C : k == 1 ? 32'hABCDC30C
            : 32'hABCD5A02);
    end
    run_req(1'b0, 2'h1, 24'h123456, 16'h0001, 32'h00000000);
    check("quiet data", rdata, 32'h00000013);
  endtask : t_kinds
  // Top register, control-valued data bytes, first missing register
  task automatic t_edges();
    run_req(1'b1, 2'h1, 24'h000102, 16'h000F, 32'h01C0C103);
    run_req(1'b0, 2'h1, 24'h000102, 16'h000F, 32'h00000000);
    check("ctl bytes", rdata, 32'h01C0C103);
    run_req(1'b1, 2'h1, 24'h000102, 16'h0010, 32'h00000001);
    check("bad wr ok", 32'(ok), 0);
    check_q("bad wr", rs, '{9'h104, 9'h101});
    run_req(1'b0, 2'h1, 24'h000102, 16'h0010, 32'h00000000);
    check_q("bad rd", rs, '{9'h104, 9'h101});
  endtask : t_edges
  task automatic t_status();
    @(negedge i_clock);
    ps_reg = 16'h0007;
    ps_wdata = 32'h5A5AA5A5;
    ps_wr = 1'b1;
    @(negedge i_clock);
    ps_wr = 1'b0;
    ps_rd = 1'b1;
    @(negedge i_clock);
    ps_rd = 1'b0;
    check("ps data", ps_rdata, 32'h5A5AA5A5);
    check("ps res", ps_res, 32'h0000070B);
  endtask : t_status
  task automatic send_tok(input logic [8:0] t);
    @(negedge i_clock);
    link2.req_valid = 1'b1;
    link2.req_tok = t;
    while (link2.req_ready !== 1'b1) @(negedge i_clock);
    @(posedge i_clock);
  endtask : send_tok
  // Stray byte, then a read cut short by an early end token
  task automatic t_malformed();
    send_tok(9'h055);
    send_tok(9'h1C1);
    send_tok(9'h000);
    send_tok(9'h101);
    @(negedge i_clock);
    link2.req_valid = 1'b0;
    repeat (8) @(negedge i_clock);
    check_q("short rsp", rs2, '{9'h104, 9'h101});
  endtask : t_malformed
  task automatic complete_run();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  initial begin
    {start, write, ps_wr, ps_rd, kind, regnum, ps_reg, reply_id, wdata, ps_wdata} = '0;
    target_id = 24'h00ABCD;
    periph = 8'h5A;
    link2.req_valid = 1'b0;
    link2.req_tok = 9'h000;
    link2.rsp_ready = 1'b1;
    repeat (8) @(negedge i_clock);
    i_rst = 1'b0;
    t_write_read();
    t_kinds();
    t_edges();
    t_status();
    t_malformed();
    complete_run();
  end
endmodule : cfgacc_tb
